// ---- src/isoa_regs.svh ----
// Purpose: register map and field layout of the input stream offset aligner
// Assumes: 32-bit APB data, one aligned word per register
// Notes: per stream a 4-bit nibble, latch edge select in bit 0, offset above it
`ifndef ISOA_REGS_SVH
`define ISOA_REGS_SVH
`define ISOA_ADDR_OFS0 8'h00
`define ISOA_ADDR_STRIDE 8'h04
`define ISOA_ADDR_CTRL 8'h10
`define ISOA_ADDR_STAT 8'h14
`define ISOA_OFS_RST 16'h0000
`define ISOA_CTRL_RST 1'b0
`define ISOA_CTRL_GCI_BIT 0
`define ISOA_FLD_W 4
`define ISOA_DLE_BIT 0
`define ISOA_OF_LSB 1
`define ISOA_OF_W 3
`define ISOA_MAX_WHOLE 3'h4
`define ISOA_STREAMS_PER_REG 4
`define ISOA_REG_W 16
`define ISOA_CLKS_PER_BIT 2
`endif

// ---- src/isoa_pkg.sv ----
// Purpose: shared types of the input stream offset aligner
// Assumes: nothing beyond the register header
// Notes: cfg layout matches one register nibble, so a slice casts directly
package isoa_pkg;
  typedef struct packed {
    logic [2:0] whole_clock_offset_field;
    logic latch_edge_select;
  } isoa_cfg_t;
  typedef struct packed {
    logic bit_val;
    logic bit_valid;
    logic frame_start;
  } isoa_rx_t;
  typedef enum logic [1:0] {LANE_IDLE, LANE_DELAY, LANE_RUN} isoa_lane_st_t;
endpackage

// ---- src/isoa_edge.sv ----
// Purpose: edge pulses for levels sampled on the system clock
// Assumes: inputs already synchronous to sys_clk_in
// Notes: pulses lag the level by one cycle; callers delay data to match
`timescale 1ns/1ps
`default_nettype none
module isoa_edge #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // levels and their edges
  input wire logic [W-1:0] level_in,
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);
  logic [W-1:0] prev;

  if (W < 1) begin : g_chk
    $error("isoa_edge: W must be at least 1");
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prev <= '0;
      rise_out <= '0;
      fall_out <= '0;
    end else begin
      prev <= level_in;
      rise_out <= level_in & ~prev;
      fall_out <= ~level_in & prev;
    end
  end
endmodule
`default_nettype wire

// ---- src/isoa_lane.sv ----
// Purpose: one input stream: frame offset delay and bit capture
// Assumes: edge pulses and data aligned to the same system clock cycle
// Notes: delay counts serial clock edges, i.e. half clock periods
`timescale 1ns/1ps
`default_nettype none
`include "isoa_regs.svh"
module isoa_lane
  import isoa_pkg::*;
#(
  parameter int CLKS_PER_BIT = `ISOA_CLKS_PER_BIT
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // timing references
  input wire logic clk_rise_in,
  input wire logic clk_fall_in,
  input wire logic frame_in,
  input wire logic gci_in,
  // settings and data
  input wire isoa_cfg_t cfg_in,
  input wire logic data_in,
  // results
  output isoa_rx_t rx_out,
  output isoa_cfg_t active_out
);
  isoa_lane_st_t st;
  logic [3:0] dly;
  logic [3:0] bit_cnt;
  logic first;
  logic lat_ev;

  if (CLKS_PER_BIT < 1 || CLKS_PER_BIT > 16) begin : g_chk
    $error("isoa_lane: CLKS_PER_BIT must be 1..16");
  end

  // gci mode swaps the meaning of the latch edge select
  assign lat_ev = (active_out.latch_edge_select ^ gci_in) ? clk_fall_in : clk_rise_in; // R3 R4

  // settings are only adopted at the frame boundary, never mid-frame
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      active_out <= '0;
    end else if (frame_in) begin
      active_out <= cfg_in; // R9
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= LANE_IDLE;
      dly <= '0;
      bit_cnt <= '0;
      first <= 1'b0;
    end else if (frame_in) begin
      st <= LANE_DELAY;
      // offset*2 + latch edge select, in half periods
      dly <= {cfg_in.whole_clock_offset_field, cfg_in.latch_edge_select}; // R1 R7
      bit_cnt <= '0;
      first <= 1'b1;
    end else begin
      unique case (st)
        LANE_IDLE: begin
        end
        LANE_DELAY: begin
          if (dly == '0) begin
            st <= LANE_RUN; // R6
          end else if (clk_rise_in || clk_fall_in) begin
            dly <= dly - 4'h1; // R7
          end
        end
        LANE_RUN: begin
          if (lat_ev) begin
            bit_cnt <= (bit_cnt == 4'(CLKS_PER_BIT - 1)) ? '0 : bit_cnt + 4'h1;
            if (bit_cnt == '0) begin
              first <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_out <= '0;
    end else begin
      rx_out.bit_valid <= (st == LANE_RUN) && lat_ev && (bit_cnt == '0) && !frame_in;
      rx_out.frame_start <= (st == LANE_RUN) && lat_ev && (bit_cnt == '0) && first && !frame_in;
      if ((st == LANE_RUN) && lat_ev && (bit_cnt == '0)) begin
        rx_out.bit_val <= data_in;
      end
    end
  end

  property p_zero_shift;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (frame_in && cfg_in == '0) ##1 !frame_in |=> st == LANE_RUN;
  endproperty
  a_zero_shift: assert property (p_zero_shift) else $error("zero setting did shift"); // R6

  property p_edge_pick;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (st == LANE_RUN && bit_cnt == '0 && !frame_in && !gci_in
     && !active_out.latch_edge_select && clk_rise_in) |=> rx_out.bit_valid;
  endproperty
  a_edge_pick: assert property (p_edge_pick) else $error("rising edge not latched"); // R3

  property p_gci_edge;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (st == LANE_RUN && gci_in && !active_out.latch_edge_select && clk_rise_in
     && !clk_fall_in) |=> !rx_out.bit_valid;
  endproperty
  a_gci_edge: assert property (p_gci_edge) else $error("gci latched on rising edge"); // R4

  property p_half_steps;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    frame_in |=> dly == {$past(cfg_in.whole_clock_offset_field),
                         $past(cfg_in.latch_edge_select)};
  endproperty
  a_half_steps: assert property (p_half_steps) else $error("delay not in half periods"); // R7
endmodule
`default_nettype wire

// ---- src/isoa_top.sv ----
// Functional notes
// R1: each stream has a three-bit offset setting the wait before capturing bit 0.
// R2: offset reaches at most four clock periods after the frame pulse.
// R3: backplane mode: latch edge clear latches on rising edge, set on falling.
// R4: GCI mode inverts it: clear selects falling edge, set selects rising.
// R5: sixteen independent offset and latch edge settings, streams 0 to 15.
// R6: all-zero setting means no shift; this is the reset default.
// R7: shift equals whole offset plus half a period when latch edge is set.
// R8: software fills settings from the measured delay bits and inverted phase flag.
// R9: new settings take effect only at a frame boundary.
//
// Purpose: per-stream input frame offset and latch edge alignment, APB programmed
// Assumes: serial clock, frame pulse and streams sampled synchronously to sys_clk_in
// Notes: APB answers with no wait states; offsets above four are stored as four
`timescale 1ns/1ps
`default_nettype none
`include "isoa_regs.svh"
module isoa_top
  import isoa_pkg::*;
#(
  parameter int N_STREAMS = 16,
  parameter int CLKS_PER_BIT = `ISOA_CLKS_PER_BIT
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // serial side
  input wire logic ser_clk_in,
  input wire logic frame_pulse_input_in,
  input wire logic [N_STREAMS-1:0] serial_input_stream_in,
  // captured bits
  output logic [N_STREAMS-1:0] rx_bit_out,
  output logic [N_STREAMS-1:0] rx_valid_out,
  output logic [N_STREAMS-1:0] rx_frame_start_out
);
  localparam int N_REGS = N_STREAMS / `ISOA_STREAMS_PER_REG;

  if (N_STREAMS < 4 || N_STREAMS > 16 || (N_STREAMS % 4) != 0) begin : g_chk
    $error("isoa_top: N_STREAMS must be 4, 8, 12 or 16");
  end

  logic [`ISOA_REG_W-1:0] ofs_reg [N_REGS];
  logic gci_mode;
  logic [N_STREAMS-1:0] pending;
  logic [N_STREAMS-1:0] set_mask;
  logic [N_STREAMS-1:0] stream_d;
  logic [N_REGS-1:0] ofs_sel;
  logic ctrl_sel;
  logic stat_sel;
  logic hit;
  logic setup_ph;
  logic wr_fire;
  logic [31:0] rd_word;
  logic [`ISOA_REG_W-1:0] wr_word;
  logic [1:0] lvl_rise;
  logic [1:0] lvl_fall;
  logic frame_ev;
  isoa_rx_t rx [N_STREAMS];
  isoa_cfg_t act [N_STREAMS];

  // whole-period offset cannot exceed four; larger values saturate
  function automatic logic [`ISOA_REG_W-1:0] clamp_word(input logic [`ISOA_REG_W-1:0] w);
    logic [`ISOA_REG_W-1:0] r;
    r = w;
    for (int j = 0; j < `ISOA_STREAMS_PER_REG; j++) begin
      if (r[j*`ISOA_FLD_W+`ISOA_OF_LSB +: `ISOA_OF_W] > `ISOA_MAX_WHOLE) begin
        r[j*`ISOA_FLD_W+`ISOA_OF_LSB +: `ISOA_OF_W] = `ISOA_MAX_WHOLE; // R2
      end
    end
    return r;
  endfunction

  assign setup_ph = psel_in && !penable_in;
  assign wr_fire = psel_in && penable_in && pready_out && pwrite_in;
  assign wr_word = clamp_word(pwdata_in[`ISOA_REG_W-1:0]);

  always_comb begin
    ofs_sel = '0;
    for (int k = 0; k < N_REGS; k++) begin
      if (paddr_in == 8'(`ISOA_ADDR_OFS0 + k * `ISOA_ADDR_STRIDE)) begin
        ofs_sel[k] = 1'b1;
      end
    end
    ctrl_sel = (paddr_in == `ISOA_ADDR_CTRL);
    stat_sel = (paddr_in == `ISOA_ADDR_STAT);
    hit = (|ofs_sel) || ctrl_sel || stat_sel;
  end

  always_comb begin
    rd_word = '0;
    for (int k = 0; k < N_REGS; k++) begin
      if (ofs_sel[k]) begin
        rd_word[`ISOA_REG_W-1:0] = ofs_reg[k];
      end
    end
    if (ctrl_sel) begin
      rd_word[`ISOA_CTRL_GCI_BIT] = gci_mode;
    end
    if (stat_sel) begin
      rd_word[N_STREAMS-1:0] = pending;
    end
  end

  // read data is registered in the setup cycle so prdata comes from a flop
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_out <= '0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= setup_ph;
      pslverr_out <= setup_ph && !hit;
      if (setup_ph) begin
        prdata_out <= pwrite_in ? 32'h0000_0000 : rd_word;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int k = 0; k < N_REGS; k++) begin
        ofs_reg[k] <= `ISOA_OFS_RST; // R6
      end
    end else begin
      for (int k = 0; k < N_REGS; k++) begin
        if (wr_fire && ofs_sel[k]) begin
          ofs_reg[k] <= wr_word; // R1 R5
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gci_mode <= `ISOA_CTRL_RST;
    end else if (wr_fire && ctrl_sel) begin
      gci_mode <= pwdata_in[`ISOA_CTRL_GCI_BIT];
    end
  end

  // a stream is pending when its stored setting changed since the last frame
  always_comb begin
    set_mask = '0;
    for (int k = 0; k < N_REGS; k++) begin
      for (int j = 0; j < `ISOA_STREAMS_PER_REG; j++) begin
        if (wr_fire && ofs_sel[k] && (wr_word[j*`ISOA_FLD_W +: `ISOA_FLD_W]
            != ofs_reg[k][j*`ISOA_FLD_W +: `ISOA_FLD_W])) begin
          set_mask[k*`ISOA_STREAMS_PER_REG+j] = 1'b1;
        end
      end
    end
  end

  // a write landing on the frame edge stays pending for the next frame
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~{N_STREAMS{frame_ev}}) | set_mask; // R9
    end
  end

  isoa_edge #(
    .W(2)
  ) u_edge (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .level_in({ser_clk_in, frame_pulse_input_in}),
    .rise_out(lvl_rise),
    .fall_out(lvl_fall)
  );

  // frame pulse is active low in backplane mode and active high in gci mode
  assign frame_ev = gci_mode ? lvl_rise[0] : lvl_fall[0]; // R2

  // data delayed to line up with the edge pulses
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stream_d <= '0;
    end else begin
      stream_d <= serial_input_stream_in;
    end
  end

  for (genvar i = 0; i < N_STREAMS; i++) begin : g_lane
    isoa_lane #(
      .CLKS_PER_BIT(CLKS_PER_BIT)
    ) u_lane (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .clk_rise_in(lvl_rise[1]),
      .clk_fall_in(lvl_fall[1]),
      .frame_in(frame_ev),
      .gci_in(gci_mode),
      .cfg_in(isoa_cfg_t'(ofs_reg[i/`ISOA_STREAMS_PER_REG]
              [(i%`ISOA_STREAMS_PER_REG)*`ISOA_FLD_W +: `ISOA_FLD_W])), // R5
      .data_in(stream_d[i]),
      .rx_out(rx[i]),
      .active_out(act[i])
    );
    assign rx_bit_out[i] = rx[i].bit_val;
    assign rx_valid_out[i] = rx[i].bit_valid;
    assign rx_frame_start_out[i] = rx[i].frame_start;
  end

  property p_ready_follows;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    setup_ph |=> pready_out;
  endproperty
  a_ready_follows: assert property (p_ready_follows) else $error("no ready after setup");

  property p_ready_single;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    pready_out && !setup_ph |=> !pready_out;
  endproperty
  a_ready_single: assert property (p_ready_single) else $error("ready held too long");

  property p_unmapped;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    setup_ph && !hit |=> pslverr_out && pready_out;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

  property p_field_cap;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    ofs_reg[0][`ISOA_OF_LSB +: `ISOA_OF_W] <= `ISOA_MAX_WHOLE;
  endproperty
  a_field_cap: assert property (p_field_cap) else $error("offset above four stored"); // R2

  property p_edge_store;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_fire && ofs_sel[0] |=> ofs_reg[0][`ISOA_DLE_BIT] == $past(pwdata_in[`ISOA_DLE_BIT]);
  endproperty
  a_edge_store: assert property (p_edge_store) else $error("latch edge bit lost"); // R5

  property p_pend_set;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (set_mask[0] || (pending[0] && !frame_ev)) |=> pending[0];
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("pending not held"); // R9

  property p_pend_clear;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    frame_ev && !set_mask[0] |=> !pending[0] ##1
      act[0] == isoa_cfg_t'(ofs_reg[0][`ISOA_FLD_W-1:0])
      || $past(wr_fire);
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("frame did not apply"); // R9

  property p_gci_write;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_fire && ctrl_sel |=> gci_mode == $past(pwdata_in[`ISOA_CTRL_GCI_BIT]);
  endproperty
  a_gci_write: assert property (p_gci_write) else $error("mode write lost"); // R4

  property p_hold_midframe;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    !frame_ev |=> act[0] == $past(act[0]);
  endproperty
  a_hold_midframe: assert property (p_hold_midframe) else $error("setting changed mid-frame"); // R9
endmodule
`default_nettype wire

// ---- test/isoa_far_end.sv ----
// Purpose: far end model, a backplane or GCI transmitter driving clock, frame pulse and streams
// Assumes: serial clock of eight system cycles, sixteen serial clocks per frame
// Notes: data is high around rising edges and low around falling edges
`timescale 1ns/1ps
`default_nettype none
module isoa_far_end #(
  parameter int N = 16
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // mode
  input wire logic gci_in,
  // serial lines
  output logic ser_clk_out,
  output logic frame_out,
  output logic [N-1:0] data_out
);
  logic [6:0] cnt;
  logic [2:0] ph;
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= 7'h00;
    end else begin
      cnt <= cnt + 7'h01;
    end
  end
  assign ph = cnt[2:0] - 3'h2;
  assign ser_clk_out = cnt[2];
  // frame edge sits mid low phase so it never meets a latch edge
  assign frame_out = gci_in ^ ~(cnt >= 7'h02 && cnt <= 7'h09);
  // data changes mid phase, so the latching edge decides the bit seen
  assign data_out = {N{~ph[2]}};
endmodule
`default_nettype wire

// ---- test/input_stream_offset_align_test.sv ----
// Purpose: self-checking bench of the input stream offset aligner
// Assumes: zero wait state APB slave, far end model of isoa_far_end
// Notes: shifts are measured against stream 0, which keeps the default setting
`timescale 1ns/1ps
`default_nettype none
`include "isoa_regs.svh"
module input_stream_offset_align_test;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic gci = 1'b0;
  logic ser_clk;
  logic frame;
  logic [15:0] sdata;
  logic [15:0] rx_bit;
  logic [15:0] rx_fs;
  logic [15:0] rx_vld;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  int t [16];
  logic b [16];

  isoa_top #(.N_STREAMS(16), .CLKS_PER_BIT(2)) u_dut (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .ser_clk_in(ser_clk),
    .frame_pulse_input_in(frame), .serial_input_stream_in(sdata), .rx_bit_out(rx_bit),
    .rx_valid_out(rx_vld), .rx_frame_start_out(rx_fs));
  isoa_far_end #(.N(16)) u_far (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .gci_in(gci),
    .ser_clk_out(ser_clk), .frame_out(frame), .data_out(sdata));

  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic finish_test;
    $display("counts: tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // first captured bit and its cycle per stream; the ceiling cuts a hang short
  always @(posedge sys_clk_in) begin
    cyc++;
    for (int i = 0; i < 16; i++) begin
      if (rx_fs[i] === 1'b1) begin
        t[i] = cyc;
        b[i] = rx_bit[i];
        chk("valid with frame start", 32'h0000_0001, 32'(rx_vld[i]));
      end
    end
    if (cyc == 6000) begin
      miscompares++;
      finish_test;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    // only the bench ceiling ends a wait for ready
    do begin
      @(posedge sys_clk_in);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("prdata", exp, r);
    chk("pslverr", 32'(err), 32'(e));
  endtask

  task automatic sync_frame;
    while (rx_fs[0] !== 1'b1) begin
      @(posedge sys_clk_in);
    end
  endtask

  // setting of table row k from a measured delay: low bits and inverted phase flag
  function automatic logic [3:0] nib(input int i);
    logic [11:0] fd;
    fd = 12'h000;
    fd[2:0] = 3'((i % 10) / 2);
    fd[11] = ((i % 10) % 2 == 0);
    return {fd[2:0], ~fd[11]};
  endfunction

  task automatic test_regs;
    for (int a = 0; a < 6; a++) begin
      rd(8'(a * 4), 32'h0000_0000, 1'b0);
    end
    rd(8'h20, 32'h0000_0000, 1'b1);
    sync_frame;
    wr(`ISOA_ADDR_OFS0, 32'hFFFF_F3A5);
    wr(8'h0C, 32'h0000_1234);
    rd(`ISOA_ADDR_STAT, 32'h0000_F00F, 1'b0);
    rd(`ISOA_ADDR_OFS0, 32'h0000_9385, 1'b0);
    rd(8'h04, 32'h0000_0000, 1'b0);
    rd(8'h0C, 32'h0000_1234, 1'b0);
    repeat (140) @(posedge sys_clk_in);
    rd(`ISOA_ADDR_STAT, 32'h0000_0000, 1'b0);
    $display("test registers done");
  endtask

  task automatic align(input logic m);
    int k;
    gci <= m;
    wr(`ISOA_ADDR_CTRL, 32'(m));
    for (int r = 0; r < 4; r++) begin
      wr(8'(r * 4), {16'h0000, nib(4 * r + 3), nib(4 * r + 2), nib(4 * r + 1), nib(4 * r)});
    end
    repeat (384) @(posedge sys_clk_in);
    sync_frame;
    repeat (60) @(posedge sys_clk_in);
    for (int i = 0; i < 16; i++) begin
      k = i % 10;
      chk("shift", 32'(k * 4), 32'(t[i] - t[0]));
      chk("latched bit", 32'(!((k % 2 == 1) ^ m)), 32'(b[i]));
    end
    $display("test alignment mode %0d done", m);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    test_regs;
    align(1'b0);
    align(1'b1);
    finish_test;
  end
endmodule
`default_nettype wire
